// ===== pkg/swm_pkg.sv
// Constants shared by the single-wire bus master: op codes, identity commands, slot timing.
// Assumes a 20 MHz system clock; all times are in nanoseconds and turned into cycle counts here.
// Function
// - Check byte polynomial x8 plus x5, x4, one.
// - Checker clears register, feeds data LSB first.
// - Shift in check byte; zero means clean.
// - Every byte travels least significant bit first.
// - Drive line only low, release when idle.
// - Idle recovery unbounded; suspend with line high.
// - Order: initialization, identity command, function command.
// - After any search, begin again with initialization.
// - Five eight-bit identity commands precede function commands.
// - Code F0h runs the elimination search.
// - Code 33h reads identity, single slave only.
// - Address-all then BEh only with single slave.
// - Each transaction opens with reset and presence.
package swm_pkg;

    localparam int CLK_NS = 50;

    localparam logic [2:0] OP_INIT   = 3'h0;
    localparam logic [2:0] OP_WRITE8 = 3'h1;
    localparam logic [2:0] OP_READ8  = 3'h2;
    localparam logic [2:0] OP_WRITE1 = 3'h3;
    localparam logic [2:0] OP_READ1  = 3'h4;
    localparam logic [2:0] OP_CRCCLR = 3'h5;

    localparam logic [7:0] ROM_SEARCH = 8'hf0;
    localparam logic [7:0] ROM_READ   = 8'h33;
    localparam logic [7:0] ROM_MATCH  = 8'h55;
    localparam logic [7:0] ROM_SKIP   = 8'hcc;
    localparam logic [7:0] ROM_ALARM  = 8'hec;
    localparam logic [7:0] FN_RDSCRATCH = 8'hbe;

    localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
    localparam logic [7:0] CRC_INIT      = 8'h00;

    localparam logic [7:0] ID_BITS     = 8'd64;
    localparam logic [7:0] SEARCH_BITS = 8'd192;

    localparam int T_RST_LOW_NS  = 480000;
    localparam int T_PRES_SMP_NS = 70000;
    localparam int T_RST_TAIL_NS = 410000;
    localparam int T_LOW1_NS     = 6000;
    localparam int T_LOW0_NS     = 60000;
    localparam int T_RD_LOW_NS   = 6000;
    localparam int T_RD_SMP_NS   = 14000;
    localparam int T_SLOT_NS     = 70000;
    localparam int T_REC_NS      = 10000;

    localparam int RST_LOW_CYC  = (T_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_TAIL_CYC = (T_RST_TAIL_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [13:0] PRES_SMP_CYC = 14'(T_PRES_SMP_NS / CLK_NS);
    localparam logic [13:0] LOW1_CYC     = 14'((T_LOW1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [13:0] LOW0_CYC     = 14'((T_LOW0_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [13:0] RD_LOW_CYC   = 14'((T_RD_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [13:0] RD_SMP_CYC   = 14'(T_RD_SMP_NS / CLK_NS);
    localparam logic [13:0] SLOT_END_CYC = 14'((T_SLOT_NS + T_REC_NS + CLK_NS - 1) / CLK_NS);

endpackage

// ===== core/single_wire_rom_layer_crc.sv
// Bus master for the single-wire sensor bus: reset/presence, bit slots, identity-layer order, CRC.
// Assumes an external pull-up on the line and a user that issues one command at a time.
`timescale 1ns/1ps
`default_nettype none
module single_wire_rom_layer_crc
    import swm_pkg::*;
#(
    parameter int RST_LOW_CYCLES  = RST_LOW_CYC,
    parameter int RST_TAIL_CYCLES = RST_TAIL_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       cmdValid,
    input  wire logic [2:0] cmdOp,
    input  wire logic [7:0] cmdData,
    input  wire logic       singleSlave,
    input  wire logic       dqIn,
    output var  logic       dqOut,
    output var  logic       dqOe,
    output var  logic       busy,
    output var  logic       done,
    output var  logic       cmdErr,
    output var  logic       presence,
    output var  logic [7:0] rxData,
    output var  logic [7:0] crc,
    output var  logic       crcZero
);

    typedef enum logic [2:0] {S_IDLE, S_RSTLOW, S_RSTWAIT, S_RSTTAIL, S_SLOT} state_e;
    typedef enum logic [2:0] {P_NEEDINIT, P_ROMCMD, P_ROMDATA, P_SEARCH, P_FUNC} phase_e;

    state_e      state_r;
    phase_e      phase_r;
    logic [13:0] cnt_r;
    logic [7:0]  shReg_r;
    logic [3:0]  bitsLeft_r;
    logic        isRead_r;
    logic        dqMeta_r;
    logic        dqSync_r;
    logic [7:0]  bitCnt_r;
    logic [7:0]  romCode_r;
    logic        firstFunc_r;
    logic        countBits_r;
    logic        dqOe_r;
    logic        dqOut_r;
    logic        busy_r;
    logic        done_r;
    logic        cmdErr_r;
    logic        presence_r;
    logic [7:0]  rxData_r;
    logic [7:0]  crc_r;
    logic        crcZero_r;

    logic        accept;
    logic        illegal;
    logic        go;
    logic        bitDone;
    logic        bitVal;
    logic [13:0] lowLen;

    function automatic logic knownRom(input logic [7:0] code);
        knownRom = (code == ROM_SEARCH) || (code == ROM_READ) || (code == ROM_MATCH)
                || (code == ROM_SKIP) || (code == ROM_ALARM);
    endfunction

    function automatic logic [7:0] crcStep(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        crcStep = {1'b0, c[7:1]} ^ (fb ? CRC_POLY_REFL : 8'h00);
    endfunction

    assign accept = cmdValid && !busy_r;
    always_comb begin
        illegal = 1'b0;
        if (cmdOp != OP_INIT && cmdOp != OP_CRCCLR && phase_r == P_NEEDINIT) begin
            illegal = 1'b1;
        end
        if (phase_r == P_ROMCMD) begin
            if (cmdOp != OP_WRITE8 && cmdOp != OP_INIT && cmdOp != OP_CRCCLR) begin
                illegal = 1'b1;
            end else if (cmdOp == OP_WRITE8 && !knownRom(cmdData)) begin
                illegal = 1'b1;
            end else if (cmdOp == OP_WRITE8 && cmdData == ROM_READ && !singleSlave) begin
                illegal = 1'b1;
            end
        end
        if (phase_r == P_FUNC && firstFunc_r && cmdOp == OP_WRITE8 && cmdData == FN_RDSCRATCH
            && romCode_r == ROM_SKIP && !singleSlave) begin
            illegal = 1'b1;
        end
    end
    assign go = accept && !illegal && cmdOp <= OP_CRCCLR;

    assign bitDone = (state_r == S_SLOT) && (cnt_r == SLOT_END_CYC - 14'h1);
    assign bitVal  = isRead_r ? shReg_r[7] : shReg_r[0];
    always_comb begin
        if (isRead_r) begin
            lowLen = RD_LOW_CYC;
        end else begin
            lowLen = shReg_r[0] ? LOW1_CYC : LOW0_CYC;
        end
    end

    // The line is asynchronous to sys_clk, so it is double-registered before any use.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dqMeta_r <= 1'b1;
            dqSync_r <= 1'b1;
        end else begin
            dqMeta_r <= dqIn;
            dqSync_r <= dqMeta_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r    <= S_IDLE;
            cnt_r      <= 14'h0;
            shReg_r    <= 8'h00;
            bitsLeft_r <= 4'h0;
            isRead_r   <= 1'b0;
            dqOe_r     <= 1'b0;
            dqOut_r    <= 1'b0;
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
            presence_r <= 1'b0;
            rxData_r   <= 8'h00;
        end else begin
            done_r  <= 1'b0;
            dqOut_r <= 1'b0;
            cnt_r   <= cnt_r + 14'h1;
            unique case (state_r)
                S_IDLE: begin
                    cnt_r  <= 14'h0;
                    dqOe_r <= 1'b0;
                    if (go && cmdOp == OP_INIT) begin
                        state_r <= S_RSTLOW;
                        dqOe_r  <= 1'b1;
                        busy_r  <= 1'b1;
                    end else if (go && cmdOp != OP_CRCCLR) begin
                        state_r    <= S_SLOT;
                        shReg_r    <= cmdData;
                        bitsLeft_r <= (cmdOp == OP_WRITE8 || cmdOp == OP_READ8) ? 4'h8 : 4'h1;
                        isRead_r   <= (cmdOp == OP_READ8 || cmdOp == OP_READ1);
                        dqOe_r     <= 1'b1;
                        busy_r     <= 1'b1;
                    end else if (go) begin
                        done_r <= 1'b1;
                    end
                end
                S_RSTLOW: begin
                    if (cnt_r == 14'(RST_LOW_CYCLES - 1)) begin
                        dqOe_r  <= 1'b0;
                        cnt_r   <= 14'h0;
                        state_r <= S_RSTWAIT;
                    end
                end
                S_RSTWAIT: begin
                    if (cnt_r == PRES_SMP_CYC - 14'h1) begin
                        presence_r <= !dqSync_r;
                        cnt_r      <= 14'h0;
                        state_r    <= S_RSTTAIL;
                    end
                end
                S_RSTTAIL: begin
                    if (cnt_r == 14'(RST_TAIL_CYCLES - 1)) begin
                        state_r <= S_IDLE;
                        busy_r  <= 1'b0;
                        done_r  <= 1'b1;
                    end
                end
                S_SLOT: begin
                    if (cnt_r == lowLen - 14'h1) begin
                        dqOe_r <= 1'b0;
                    end
                    if (isRead_r && cnt_r == RD_SMP_CYC - 14'h1) begin
                        shReg_r <= {dqSync_r, shReg_r[7:1]};
                    end
                    if (bitDone) begin
                        cnt_r <= 14'h0;
                        if (!isRead_r) begin
                            shReg_r <= {1'b0, shReg_r[7:1]};
                        end
                        if (bitsLeft_r == 4'h1) begin
                            state_r  <= S_IDLE;
                            busy_r   <= 1'b0;
                            done_r   <= 1'b1;
                            rxData_r <= (bitsLeft_r == 4'h1 && isRead_r) ? shReg_r : rxData_r;
                        end else begin
                            bitsLeft_r <= bitsLeft_r - 4'h1;
                            dqOe_r     <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // A refused command never starts a slot, so the device never sees an out-of-order step.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmdErr_r <= 1'b0;
        end else begin
            cmdErr_r <= accept && illegal;
        end
    end

    // The identity command's own slots run after the phase has moved on, so they must not count.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            countBits_r <= 1'b0;
        end else if (state_r == S_IDLE && go) begin
            countBits_r <= (phase_r == P_ROMDATA || phase_r == P_SEARCH);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phase_r     <= P_NEEDINIT;
            bitCnt_r    <= 8'h00;
            romCode_r   <= 8'h00;
            firstFunc_r <= 1'b0;
        end else if (state_r == S_RSTWAIT && cnt_r == PRES_SMP_CYC - 14'h1) begin
            phase_r <= dqSync_r ? P_NEEDINIT : P_ROMCMD;
        end else if (go && cmdOp == OP_INIT) begin
            phase_r <= P_NEEDINIT;
        end else if (go && phase_r == P_ROMCMD && cmdOp == OP_WRITE8) begin
            romCode_r   <= cmdData;
            bitCnt_r    <= 8'h00;
            firstFunc_r <= 1'b1;
            if (cmdData == ROM_SKIP) begin
                phase_r <= P_FUNC;
            end else if (cmdData == ROM_SEARCH || cmdData == ROM_ALARM) begin
                phase_r <= P_SEARCH;
            end else begin
                phase_r <= P_ROMDATA;
            end
        end else if (go && phase_r == P_FUNC && cmdOp != OP_CRCCLR) begin
            firstFunc_r <= 1'b0;
        end else if (bitDone && countBits_r && (phase_r == P_ROMDATA || phase_r == P_SEARCH)) begin
            bitCnt_r <= bitCnt_r + 8'h1;
            if (phase_r == P_ROMDATA && bitCnt_r == ID_BITS - 8'h1) begin
                phase_r <= P_FUNC;
            end
            if (phase_r == P_SEARCH && bitCnt_r == SEARCH_BITS - 8'h1) begin
                phase_r <= P_NEEDINIT;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            crc_r     <= CRC_INIT;
            crcZero_r <= 1'b1;
        end else begin
            if (go && cmdOp == OP_CRCCLR) begin
                crc_r <= CRC_INIT;
            end else if (bitDone) begin
                crc_r <= crcStep(crc_r, bitVal);
            end
            crcZero_r <= (crc_r == 8'h00);
        end
    end

    assign dqOut    = dqOut_r;
    assign dqOe     = dqOe_r;
    assign busy     = busy_r;
    assign done     = done_r;
    assign cmdErr   = cmdErr_r;
    assign presence = presence_r;
    assign rxData   = rxData_r;
    assign crc      = crc_r;
    assign crcZero  = crcZero_r;

    AST_CRC_POLY: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bitDone && !(go && cmdOp == OP_CRCCLR) |=>
            crc_r == (({1'b0, $past(crc_r[7:1])})
                      ^ (($past(crc_r[0]) ^ $past(bitVal)) ? 8'h8c : 8'h00)))
        else $error("check byte update does not follow the polynomial");
    AST_CRC_CLEAR: assert property (@(posedge sys_clk) disable iff (sys_rst)
        accept && cmdOp == OP_CRCCLR && !illegal |=> crc_r == 8'h00 ##1 crcZero_r)
        else $error("check register not cleared");
    AST_CRC_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
        crc_r != 8'h00 |=> !crcZero_r)
        else $error("zero flag set with nonzero register");
    AST_LSB_FIRST: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state_r == S_IDLE && go && cmdOp == OP_WRITE8 && !cmdData[0] |-> ##200 dqOe_r)
        else $error("first written bit is not the least significant one");
    AST_LSB_FIRST_ONE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state_r == S_IDLE && go && cmdOp == OP_WRITE8 && cmdData[0] |-> ##200 !dqOe_r)
        else $error("first written one bit is not the least significant one");
    AST_IDLE_RELEASE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state_r == S_IDLE |-> !dqOut_r ##1 (state_r != S_IDLE || !dqOe_r))
        else $error("line held or driven high while idle");
    AST_ORDER: assert property (@(posedge sys_clk) disable iff (sys_rst)
        accept && phase_r == P_NEEDINIT && cmdOp == OP_WRITE8 |=> cmdErr_r && !busy_r)
        else $error("byte sent without initialization");
    AST_SEARCH_REINIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bitDone && countBits_r && phase_r == P_SEARCH && bitCnt_r == 8'd191 |=> phase_r == P_NEEDINIT)
        else $error("search not followed by a forced initialization");
    AST_ROM_CODE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        accept && phase_r == P_ROMCMD && cmdOp == OP_WRITE8 && !knownRom(cmdData)
            |=> cmdErr_r ##1 state_r == S_IDLE)
        else $error("unknown identity command was not refused");
    AST_READ_SINGLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        accept && phase_r == P_ROMCMD && cmdOp == OP_WRITE8 && cmdData == 8'h33 && !singleSlave
            |=> cmdErr_r && phase_r == P_ROMCMD)
        else $error("identity read allowed on a shared bus");
    AST_RESET_PULSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state_r == S_IDLE && go && cmdOp == OP_INIT |=> dqOe_r [*8] ##0 state_r == S_RSTLOW)
        else $error("reset pulse not driven");

    COV_PRESENCE: cover property (@(posedge sys_clk) disable iff (sys_rst)
        state_r == S_RSTTAIL && presence_r);
    COV_READ_BYTE: cover property (@(posedge sys_clk) disable iff (sys_rst)
        bitDone && isRead_r && bitsLeft_r == 4'h1 && bitCnt_r == 8'd7);
    COV_SEARCH_DONE: cover property (@(posedge sys_clk) disable iff (sys_rst)
        phase_r == P_SEARCH ##1 phase_r == P_NEEDINIT);
    COV_CRC_OK: cover property (@(posedge sys_clk) disable iff (sys_rst)
        bitDone ##2 crcZero_r);

endmodule
`default_nettype wire

// ===== tb/sw_device_model.sv
// Behavioural model of one temperature sensor slave on the open-drain single-wire line.
// Assumes the bench resolves the wire from every party's pull-down and a pull-up to high.
`timescale 1ns/1ps
`default_nettype none
module sw_device_model #(
    parameter int          RST_MIN_NS = 70000,
    parameter logic [7:0]  FAMILY     = 8'h5a,            // Arbitrary value, names no real part.
    parameter logic [47:0] SERIAL     = 48'h0123_4567_89ab
) (
    input  wire logic       dq,
    output var  logic       pullLow,
    output var  logic [7:0] lastCmd,
    output var  logic [7:0] lastFn
);
    logic [63:0] rom;
    logic [63:0] shiftOut;
    logic [7:0]  shiftIn;
    logic [63:0] matchIn;
    int          mode;     // 0 ignore, 1 identity command, 2 send identity, 3 function, 4 match.
    int          nBits;
    realtime     tFall;

    function automatic logic [7:0] crcBits(input logic [63:0] d, input int n);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < n; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ 8'h8c) : (r >> 1);
        end
        return r;
    endfunction

    initial begin
        rom = {8'h00, SERIAL, FAMILY};
        rom[63:56] = crcBits(rom, 56);
        pullLow = 1'b0;
        mode = 0;
        nBits = 0;
        lastCmd = 8'h00;
        lastFn = 8'h00;
        shiftIn = 8'h00;
        matchIn = 64'h0;
        shiftOut = 64'h0;
        forever begin
            @(negedge dq iff !pullLow);
            tFall = $realtime;
            if (mode == 2) begin
                pullLow = ~shiftOut[0];
                #30000;
                pullLow = 1'b0;
                shiftOut = shiftOut >> 1;
                nBits++;
                if (nBits == 64) mode = 0;
            end
            wait (dq === 1'b1);
            if ($realtime - tFall > RST_MIN_NS) begin
                #20000;
                pullLow = 1'b1;
                #100000;
                pullLow = 1'b0;
                mode = 1;
                nBits = 0;
            end else if (mode == 4) begin
                matchIn = {1'($realtime - tFall < 15000), matchIn[63:1]};
                nBits++;
                if (nBits == 64) begin
                    nBits = 0;
                    mode = (matchIn == rom) ? 3 : 0;
                end
            end else if (mode == 1 || mode == 3) begin
                shiftIn = {1'($realtime - tFall < 15000), shiftIn[7:1]};
                nBits++;
                if (nBits == 8) begin
                    nBits = 0;
                    if (mode == 3) begin
                        lastFn = shiftIn;
                        mode = 0;
                    end else begin
                        lastCmd = shiftIn;
                        case (shiftIn)
                            8'h33: begin
                                mode = 2;
                                shiftOut = rom;
                            end
                            8'hcc: mode = 3;
                            8'h55: mode = 4;
                            default: mode = 0;
                        endcase
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the single-wire bus master against one modelled slave.
// Assumes the slave model above; the reset pulse is shortened so a whole run stays short.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import swm_pkg::*;
    localparam logic [7:0] FAM = 8'h5a;
    logic       sys_clk;
    logic       sys_rst;
    logic       cmdValid;
    logic [2:0] cmdOp;
    logic [7:0] cmdData;
    logic       singleSlave;
    logic       dqOut;
    logic       dqOe;
    logic       busy;
    logic       done;
    logic       cmdErr;
    logic       presence;
    logic [7:0] rxData;
    logic [7:0] crc;
    logic       crcZero;
    logic       devPull;
    logic [7:0] lastCmd;
    logic [7:0] lastFn;
    wire        dqLine = (dqOe | devPull) ? 1'b0 : 1'b1;
    int         miscompares;
    int         n_tests;
    logic [31:0] rng;
    logic       gotDone;
    logic       gotErr;
    int         expCrc;
    logic [7:0] bad;

    // The reset pulse stays longer than a write-zero slot so the slave can tell them apart.
    single_wire_rom_layer_crc #(.RST_LOW_CYCLES(1600), .RST_TAIL_CYCLES(3000)) uut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdData(cmdData), .singleSlave(singleSlave), .dqIn(dqLine), .dqOut(dqOut),
        .dqOe(dqOe), .busy(busy), .done(done), .cmdErr(cmdErr), .presence(presence),
        .rxData(rxData), .crc(crc), .crcZero(crcZero));

    sw_device_model #(.FAMILY(FAM)) dev (
        .dq(dqLine), .pullLow(devPull), .lastCmd(lastCmd), .lastFn(lastFn));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic int crcByte(input int c, input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            c = ((c ^ b[i]) & 1) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
        end
        return c;
    endfunction

    task automatic final_report();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One request, then a bounded wait for its done or refusal pulse.
    task automatic issue(input logic [2:0] op, input logic [7:0] d);
        int i;
        @(negedge sys_clk);
        cmdValid = 1'b1;
        cmdOp = op;
        cmdData = d;
        @(negedge sys_clk);
        cmdValid = 1'b0;
        gotDone = (done === 1'b1);
        gotErr = (cmdErr === 1'b1);
        for (i = 0; i < 30000 && !gotDone && !gotErr; i++) begin
            @(negedge sys_clk);
            gotDone = (done === 1'b1);
            gotErr = (cmdErr === 1'b1);
        end
        if (!gotDone && !gotErr) begin
            miscompares++;
            $display("CHECK FAILED %0t no answer to a command", $time);
            final_report();
        end
    endtask

    initial begin
        miscompares = 0;
        n_tests = 0;
        rng = 32'h0b53418e;
        sys_rst = 1'b1;
        cmdValid = 1'b0;
        cmdOp = 3'h0;
        cmdData = 8'h00;
        singleSlave = 1'b0;
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        check8(crc, 8'h00, "crc after reset");
        issue(OP_WRITE8, ROM_READ);
        check8({6'h0, gotErr, gotDone}, 8'h02, "command before init");
        issue(OP_INIT, 8'h00);
        check8({7'h0, presence}, 8'h01, "presence");
        do begin
            rng = xorshift(rng);
            bad = rng[7:0];
        end while (bad inside {ROM_SEARCH, ROM_READ, ROM_MATCH, ROM_SKIP, ROM_ALARM});
        issue(OP_WRITE8, bad);
        check8({6'h0, gotErr, gotDone}, 8'h02, "unknown identity command");
        issue(OP_WRITE8, ROM_READ);
        check8({6'h0, gotErr, gotDone}, 8'h02, "read identity with many slaves");
        issue(OP_CRCCLR, rng[15:8]);
        singleSlave = 1'b1;
        issue(OP_WRITE8, ROM_READ);
        check8(lastCmd, ROM_READ, "command byte on the wire");
        issue(OP_READ8, 8'h00);
        check8(rxData, FAM, "family byte");
        expCrc = crcByte(crcByte(0, ROM_READ), FAM);
        check8(crc, 8'(expCrc), "running check byte");
        check8({7'h0, crcZero}, {7'h0, expCrc == 0}, "check byte zero flag");
        singleSlave = 1'b0;
        issue(OP_INIT, 8'h00);
        issue(OP_WRITE8, ROM_SKIP);
        check8({6'h0, gotErr, gotDone}, 8'h01, "address all");
        issue(OP_WRITE8, FN_RDSCRATCH);
        check8({6'h0, gotErr, gotDone}, 8'h02, "scratch read after address all");
        singleSlave = 1'b1;
        issue(OP_WRITE8, FN_RDSCRATCH);
        check8(lastFn, FN_RDSCRATCH, "function byte reaches slave");
        issue(OP_WRITE1, {7'h0, rng[16]});
        check8({6'h0, gotErr, gotDone}, 8'h01, "single bit write");
        issue(OP_READ1, 8'h00);
        check8({7'h0, rxData[7]}, 8'h01, "released line reads high");
        check8({6'h0, busy, dqOut}, 8'h00, "outputs idle after done");
        issue(OP_INIT, 8'h00);
        issue(OP_WRITE8, ROM_SEARCH);
        check8(lastCmd, ROM_SEARCH, "search command on the wire");
        final_report();
    end
endmodule
`default_nettype wire
